// file: hdl/decoder_lock_state_monitor_regs.sv
/*
  Register bank for decoder control, status, event flags and the
  observation word, reached through the internal side of the two-wire
  serial port. Also drives the status pin, interrupt pin and the
  transport output clock selection.
  Assumes the serial port logic and all datapath inputs share ref_clk_i;
  only the transport input clock pin is asynchronous.
*/
`default_nettype none

// Behaviour
// - Read-only 16-bit symbol rate readback, two bytes
// - Select 0 gives I/Q from one symbol
// - Select 1 gives I/Q input offsets
// - Select 3 gives locked rate times 1024
// - Select 5 top bits give decimation index
// - Select 6 gives frequency detector byte twice
// - Select 7 timing detector, reads leave it
// - Select 8 phase detector, reads leave it
// - Enable bits gate events onto interrupt pin
// - Flags latch events; reading clears all
// - Status pin ORs the selected status signals
// - Ratio field plus six; reset value 14h
// - Tone bit drives error-rate toggle on status
// - Non-manual: bit7 stops rate-derived output clock
// - Manual: bit7 passes input clock, else ratio
// - Setup bits steer test clock, decoder bypasses
// - Setup bit2 selects programmed sync byte
// - Sync loss after field plus two bad words
// - Status bits 6..4 report code rate
// - Live lock bits 3..1; bits 7,0 zero
// - Period expiry coincides with count update
module decoder_lock_state_monitor_regs #(
  parameter int TONE_ERRORS = 64  // Corrected bits per tone half-period
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Register port from the serial interface
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Datapath state
  input wire logic [15:0] symbol_rate_readback_i,
  input wire logic [3:0] observation_select_i,
  input wire logic [7:0] carrier_sync_i_sample_i,
  input wire logic [7:0] carrier_sync_q_sample_i,
  input wire logic sample_valid_i,
  input wire decoder_lock_state_pkg::obs_source_s obs_source_i,
  input wire decoder_lock_state_pkg::lock_state_s lock_state_i,
  input wire logic [7:0] decoder_events_i,
  input wire logic viterbi_error_pulse_i,
  input wire logic [23:0] viterbi_corrected_count_i,
  // Output clock sources
  input wire logic manual_output_clock_mode_i,
  input wire logic rate_clock_i,
  input wire logic transport_input_clock_i,
  // Pins
  output logic irq_n_o,
  output logic status_o,
  output logic transport_output_clock_o,
  // Decoder controls
  output logic test_clock_out_en_o,
  output logic descrambler_off_o,
  output logic reed_solomon_off_o,
  output logic viterbi_bypass_o,
  output logic custom_sync_byte_en_o,
  output logic [2:0] sync_loss_threshold_o,
  output logic [23:0] viterbi_corrected_count_o
);

  // ----------------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------------
  if (TONE_ERRORS < 2 || TONE_ERRORS > 65535) begin : g_tone_check
    $error("TONE_ERRORS must lie between 2 and 65535");
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [7:0] flags_q;        // Sticky decoder events
  logic [7:0] flags_d;
  logic [7:0] enables_q;      // Event enables onto the interrupt pin
  logic [7:0] pin_select_q;   // Ratio field and status pin selects
  logic [7:0] setup_q;        // Decoder setup
  logic [7:0] rdata_q;        // Registered read answer
  logic [7:0] iq_i_q;         // I and Q held as one pair
  logic [7:0] iq_q_q;
  logic [15:0] tone_count_q;  // Corrected bits since last tone edge
  logic tone_q;               // Error-rate tone level
  logic irq_n_q;
  logic status_q;
  logic out_clk_q;
  logic [23:0] vit_count_q;   // Corrected count snapshot
  logic [2:0] thr_q;          // Sync loss threshold, field plus two
  logic in_clk_meta_q;        // Synchroniser first stage
  logic in_clk_sync_q;        // Synchroniser second stage
  logic div_clk;              // Ratio-derived clock
  logic [15:0] obs_word;      // Selected observation word
  logic clear_flags;          // Host read of the flag register

  localparam logic [15:0] TONE_LAST = 16'(TONE_ERRORS - 1);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Address match for a host write
  function automatic logic wr_hit(input logic wr, input logic [7:0] a,
                                  input logic [7:0] target);
    wr_hit = wr && (a == target);
  endfunction : wr_hit

  // Live lock state byte; reserved bits stay zero
  function automatic logic [7:0] lock_byte(
      input decoder_lock_state_pkg::lock_state_s s);
    lock_byte = {1'b0, s.code_rate, s.descrambler_locked,
                 s.byte_align_locked, s.viterbi_locked, 1'b0};
  endfunction : lock_byte

  // ----------------------------------------------------------------------
  // Observation word selection
  // ----------------------------------------------------------------------
  // Unlisted codes read zero; host is expected to avoid them
  always_comb begin
    obs_word = 16'h0000;
    case (observation_select_i)
      decoder_lock_state_pkg::OBS_IQ_SAMPLE: begin
        obs_word = {iq_i_q, iq_q_q};
      end
      decoder_lock_state_pkg::OBS_INPUT_OFFSET: begin
        obs_word = {obs_source_i.input_offset_i,
                    obs_source_i.input_offset_q};
      end
      decoder_lock_state_pkg::OBS_LOCKED_RATE: begin
        // Only meaningful once a search has locked
        if (obs_source_i.rate_search_locked) begin
          obs_word = obs_source_i.locked_rate_readout;
        end
      end
      decoder_lock_state_pkg::OBS_DEC_RATIO: begin
        obs_word = {obs_source_i.dec_ratio_index, 13'h0000};
      end
      decoder_lock_state_pkg::OBS_FREQ_LOCK: begin
        obs_word = {obs_source_i.freq_lock_detector_value,
                    obs_source_i.freq_lock_detector_value};
      end
      decoder_lock_state_pkg::OBS_TIMING_LOCK: begin
        obs_word = obs_source_i.timing_lock_detector_value;
      end
      decoder_lock_state_pkg::OBS_PHASE_LOCK: begin
        obs_word = obs_source_i.phase_lock_detector_value;
      end
      default: begin
        obs_word = 16'h0000;
      end
    endcase
  end

  // Both halves load together so a scatter point never mixes symbols
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      iq_i_q <= 8'h00;
      iq_q_q <= 8'h00;
    end else if (sample_valid_i) begin
      iq_i_q <= carrier_sync_i_sample_i;
      iq_q_q <= carrier_sync_q_sample_i;
    end
  end

  // ----------------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------------
  // Enables
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      enables_q <= decoder_lock_state_pkg::RESET_EVENT_ENABLES;
    end else if (wr_hit(reg_wr_i, reg_addr_i,
                        decoder_lock_state_pkg::ADDR_EVENT_ENABLES)) begin
      enables_q <= reg_wdata_i;
    end
  end

  // Ratio field and status pin selects
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      pin_select_q <= decoder_lock_state_pkg::RESET_STATUS_PIN_SELECT;
    end else if (wr_hit(reg_wr_i, reg_addr_i,
                        decoder_lock_state_pkg::ADDR_STATUS_PIN_SELECT)) begin
      pin_select_q <= reg_wdata_i;
    end
  end

  // Decoder setup
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      setup_q <= decoder_lock_state_pkg::RESET_DECODER_SETUP;
    end else if (wr_hit(reg_wr_i, reg_addr_i,
                        decoder_lock_state_pkg::ADDR_DECODER_SETUP)) begin
      setup_q <= reg_wdata_i;
    end
  end

  // ----------------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------------
  assign clear_flags = reg_rd_i &&
                       (reg_addr_i == decoder_lock_state_pkg::ADDR_EVENT_FLAGS);

  // New events are ORed in after the clear so none is lost
  always_comb begin
    flags_d = clear_flags ? 8'h00 : flags_q;
    flags_d = flags_d | decoder_events_i;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      flags_q <= 8'h00;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Threshold held in its own flop so the output carries no adder
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      thr_q <= {1'b0, decoder_lock_state_pkg::RESET_DECODER_SETUP[1:0]} +
               decoder_lock_state_pkg::SYNC_LOSS_OFFSET;
    end else if (wr_hit(reg_wr_i, reg_addr_i,
                        decoder_lock_state_pkg::ADDR_DECODER_SETUP)) begin
      thr_q <= {1'b0, reg_wdata_i[1:0]} +
               decoder_lock_state_pkg::SYNC_LOSS_OFFSET;
    end
  end

  // Snapshot taken on the very edge that raises the expiry flag
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      vit_count_q <= 24'h000000;
    end else if (decoder_events_i[decoder_lock_state_pkg::EVENT_PERIOD_BIT]) begin
      vit_count_q <= viterbi_corrected_count_i;
    end
  end

  // Interrupt pin low while any enabled flag stands
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      irq_n_q <= 1'b1;
    end else begin
      irq_n_q <= ~|(flags_q & enables_q);
    end
  end

  // ----------------------------------------------------------------------
  // Read answer
  // ----------------------------------------------------------------------
  // Reads never touch the detectors, only the flag register clears
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      rdata_q <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        decoder_lock_state_pkg::ADDR_EVENT_FLAGS: rdata_q <= flags_q;
        decoder_lock_state_pkg::ADDR_LOCK_STATE: rdata_q <= lock_byte(lock_state_i);
        decoder_lock_state_pkg::ADDR_EVENT_ENABLES: rdata_q <= enables_q;
        decoder_lock_state_pkg::ADDR_STATUS_PIN_SELECT: rdata_q <= pin_select_q;
        decoder_lock_state_pkg::ADDR_DECODER_SETUP: rdata_q <= setup_q;
        decoder_lock_state_pkg::ADDR_RATE_READBACK_HIGH: begin
          rdata_q <= symbol_rate_readback_i[15:8];
        end
        decoder_lock_state_pkg::ADDR_RATE_READBACK_LOW: begin
          rdata_q <= symbol_rate_readback_i[7:0];
        end
        decoder_lock_state_pkg::ADDR_OBSERVATION_HIGH: rdata_q <= obs_word[15:8];
        decoder_lock_state_pkg::ADDR_OBSERVATION_LOW: rdata_q <= obs_word[7:0];
        // Addresses outside this bank answer zero
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Error-rate tone and status pin
  // ----------------------------------------------------------------------
  // Toggle every TONE_ERRORS corrected bits: pitch rises with error rate
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      tone_count_q <= 16'h0000;
      tone_q <= 1'b0;
    end else if (viterbi_error_pulse_i) begin
      if (tone_count_q >= TONE_LAST) begin
        tone_count_q <= 16'h0000;
        tone_q <= ~tone_q;
      end else begin
        tone_count_q <= tone_count_q + 16'h0001;
      end
    end
  end

  // OR of every selected status source
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      status_q <= 1'b0;
    end else begin
      status_q <= (pin_select_q[decoder_lock_state_pkg::SEL_DESCRAMBLER_LOCKED] &&
                   lock_state_i.descrambler_locked) ||
                  (pin_select_q[decoder_lock_state_pkg::SEL_BA_LOCK] &&
                   lock_state_i.byte_align_locked) ||
                  (pin_select_q[decoder_lock_state_pkg::SEL_VITERBI_LOCKED] &&
                   lock_state_i.viterbi_locked) ||
                  (pin_select_q[decoder_lock_state_pkg::SEL_TONE] &&
                   tone_q);
    end
  end

  // ----------------------------------------------------------------------
  // Transport output clock
  // ----------------------------------------------------------------------
  // The input clock pin is asynchronous; only the second stage is used
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      in_clk_meta_q <= 1'b0;
      in_clk_sync_q <= 1'b0;
    end else begin
      in_clk_meta_q <= transport_input_clock_i;
      in_clk_sync_q <= in_clk_meta_q;
    end
  end

  output_clock_divider #(
    .WIDTH(5)
  ) u_divider (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .period_i({1'b0, pin_select_q[7:4]} +
              decoder_lock_state_pkg::CLOCK_RATIO_OFFSET),
    .div_clk_o(div_clk)
  );

  // Passing the pin through costs up to three reference cycles of lag
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      out_clk_q <= 1'b0;
    end else if (manual_output_clock_mode_i) begin
      out_clk_q <= setup_q[decoder_lock_state_pkg::SETUP_SRC_SEL] ?
                   in_clk_sync_q : div_clk;
    end else begin
      out_clk_q <= setup_q[decoder_lock_state_pkg::SETUP_SRC_SEL] ?
                   1'b0 : rate_clock_i;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign reg_rdata_o = rdata_q;
  assign irq_n_o = irq_n_q;
  assign status_o = status_q;
  assign transport_output_clock_o = out_clk_q;
  assign viterbi_corrected_count_o = vit_count_q;
  // Setup bits go straight out of their register; the threshold comes from thr_q
  assign test_clock_out_en_o = setup_q[decoder_lock_state_pkg::SETUP_TEST_CLK];
  assign descrambler_off_o = setup_q[decoder_lock_state_pkg::SETUP_DS_OFF];
  assign reed_solomon_off_o = setup_q[decoder_lock_state_pkg::SETUP_RS_OFF];
  assign viterbi_bypass_o = setup_q[decoder_lock_state_pkg::SETUP_VIT_BYPASS];
  assign custom_sync_byte_en_o =
      setup_q[decoder_lock_state_pkg::SETUP_CUSTOM_SYNC];
  assign sync_loss_threshold_o = thr_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_flag_set_wins: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    decoder_events_i[0] |=> flags_q[0])
    else $error("event lost while flags were cleared");

  a_flag_read_clear: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (clear_flags && decoder_events_i == 8'h00) |=> flags_q == 8'h00)
    else $error("flag read did not clear flags");

  a_irq_enabled_event: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (decoder_events_i[3] && enables_q[3] &&
     $stable(enables_q)) |-> ##[1:2] !irq_n_o)
    else $error("enabled event did not raise interrupt");

  a_status_or_sel: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (pin_select_q[3:1] == 3'b000 && !pin_select_q[0]) |=> !status_o)
    else $error("status pin high with nothing selected");

  a_rate_readback: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (reg_rd_i && reg_addr_i == decoder_lock_state_pkg::ADDR_RATE_READBACK_HIGH)
    |=> reg_rdata_o == $past(symbol_rate_readback_i[15:8]))
    else $error("rate readback high byte wrong");

  a_obs_offset_read: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (reg_rd_i && reg_addr_i == decoder_lock_state_pkg::ADDR_OBSERVATION_LOW &&
     observation_select_i == decoder_lock_state_pkg::OBS_INPUT_OFFSET)
    |=> reg_rdata_o == $past(obs_source_i.input_offset_q))
    else $error("offset observation low byte wrong");

  a_lock_reserved: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (reg_rd_i && reg_addr_i == decoder_lock_state_pkg::ADDR_LOCK_STATE)
    |=> (!reg_rdata_o[7] && !reg_rdata_o[0] &&
         reg_rdata_o[3] == $past(lock_state_i.descrambler_locked)))
    else $error("lock state byte wrong");

  a_sync_loss_count: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    wr_hit(reg_wr_i, reg_addr_i, decoder_lock_state_pkg::ADDR_DECODER_SETUP)
    |=> sync_loss_threshold_o == {1'b0, $past(reg_wdata_i[1:0])} + 3'd2)
    else $error("sync loss threshold not field plus two");

  a_clock_stopped: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (!manual_output_clock_mode_i && setup_q[7])[*2]
    |-> !transport_output_clock_o)
    else $error("output clock runs while stopped");

  a_bypass_follows: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    wr_hit(reg_wr_i, reg_addr_i, decoder_lock_state_pkg::ADDR_DECODER_SETUP)
    |=> viterbi_bypass_o == $past(reg_wdata_i[3]))
    else $error("viterbi bypass not taken from setup");

endmodule : decoder_lock_state_monitor_regs

`default_nettype wire

// file: hdl/decoder_lock_state_pkg.sv
/*
  Shared constants and carriers of the decoder status and monitor register
  bank: register addresses, reset values, field positions, observation
  select codes and the packed structs that carry datapath state.
  Assumes every user refers to its items as decoder_lock_state_pkg::name.
*/
`default_nettype none

package decoder_lock_state_pkg;

  // ----------------------------------------------------------------------
  // Register addresses on the serial register port
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h03;
  localparam logic [7:0] ADDR_LOCK_STATE = 8'h06;
  localparam logic [7:0] ADDR_EVENT_ENABLES = 8'h1F;
  localparam logic [7:0] ADDR_STATUS_PIN_SELECT = 8'h21;
  localparam logic [7:0] ADDR_DECODER_SETUP = 8'h61;
  localparam logic [7:0] ADDR_RATE_READBACK_HIGH = 8'h74;
  localparam logic [7:0] ADDR_RATE_READBACK_LOW = 8'h75;
  localparam logic [7:0] ADDR_OBSERVATION_HIGH = 8'h7B;
  localparam logic [7:0] ADDR_OBSERVATION_LOW = 8'h7C;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RESET_EVENT_ENABLES = 8'h00;
  localparam logic [7:0] RESET_STATUS_PIN_SELECT = 8'h14;
  localparam logic [7:0] RESET_DECODER_SETUP = 8'h03;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int SEL_DESCRAMBLER_LOCKED = 3;      // Status select: descrambler lock
  localparam int SEL_BA_LOCK = 2;      // Status select: byte-align lock
  localparam int SEL_VITERBI_LOCKED = 1;     // Status select: Viterbi lock
  localparam int SEL_TONE = 0;         // Status select: error-rate tone
  localparam int SETUP_SRC_SEL = 7;    // Output clock source select
  localparam int SETUP_TEST_CLK = 6;
  localparam int SETUP_DS_OFF = 5;
  localparam int SETUP_RS_OFF = 4;
  localparam int SETUP_VIT_BYPASS = 3;
  localparam int SETUP_CUSTOM_SYNC = 2;
  localparam int EVENT_PERIOD_BIT = 2; // Viterbi error period expiry

  // Offsets added to coded fields
  localparam logic [4:0] CLOCK_RATIO_OFFSET = 5'h06;
  localparam logic [2:0] SYNC_LOSS_OFFSET = 3'h2;

  // ----------------------------------------------------------------------
  // Observation select codes
  // ----------------------------------------------------------------------
  localparam logic [3:0] OBS_IQ_SAMPLE = 4'h0;
  localparam logic [3:0] OBS_INPUT_OFFSET = 4'h1;
  localparam logic [3:0] OBS_LOCKED_RATE = 4'h3;
  localparam logic [3:0] OBS_DEC_RATIO = 4'h5;
  localparam logic [3:0] OBS_FREQ_LOCK = 4'h6;
  localparam logic [3:0] OBS_TIMING_LOCK = 4'h7;
  localparam logic [3:0] OBS_PHASE_LOCK = 4'h8;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] code_rate;           // 0..5 for rates 1/2 .. 7/8
    logic descrambler_locked;
    logic byte_align_locked;
    logic viterbi_locked;
  } lock_state_s;

  typedef struct packed {
    logic [7:0] input_offset_i;
    logic [7:0] input_offset_q;
    logic rate_search_locked;
    logic [15:0] locked_rate_readout;
    logic [2:0] dec_ratio_index;
    logic [7:0] freq_lock_detector_value;
    logic [15:0] timing_lock_detector_value;
    logic [15:0] phase_lock_detector_value;
  } obs_source_s;

endpackage : decoder_lock_state_pkg

`default_nettype wire

// file: hdl/output_clock_divider.sv
/*
  Free-running divider that makes the transport output clock from the
  reference clock, with a period set in reference cycles.
  Assumes the period input is steady or changes only between periods.
*/
`default_nettype none

module output_clock_divider #(
  parameter int WIDTH = 5
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Period in reference cycles
  input wire logic [WIDTH-1:0] period_i,
  // Divided clock
  output logic div_clk_o
);

  // ----------------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------------
  if (WIDTH < 2) begin : g_width_check
    $error("output_clock_divider needs WIDTH of two or more");
  end

  logic [WIDTH-1:0] count_q;  // Position within the period
  logic div_clk_q;            // Registered output level

  // Count through one period; the reason for restarting on overrun is
  // that a shrinking period must not leave the counter past its end
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      count_q <= '0;
    end else if (count_q >= period_i - WIDTH'(1)) begin
      count_q <= '0;
    end else begin
      count_q <= count_q + WIDTH'(1);
    end
  end

  // High for the first half of the period, so odd ratios run low longer
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      div_clk_q <= 1'b0;
    end else begin
      div_clk_q <= (count_q < (period_i >> 1));
    end
  end

  assign div_clk_o = div_clk_q;

endmodule : output_clock_divider

`default_nettype wire

// file: testbench/decoder_lock_state_monitor_regs_tb.sv
/* Self-checking bench of the status register bank.
   Assumes the host model owns the strobe port. */
`default_nettype none
module decoder_lock_state_monitor_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] ad, wd, rq, d, ci = 8'h00, cq = 8'h00, ev = 8'h00, e;
  logic wr, rd, sv = 1'b0, vp = 1'b0, irq_n, st, oc;
  logic [23:0] vco, vc = 24'h000000;
  logic [3:0] c, codes [7] = '{4'h0, 4'h1, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8};
  logic [3:0] sel = 4'h0;
  logic [4:0] so;
  logic [2:0] thr;
  logic [31:0] lf = 32'hF6687F6F;
  decoder_lock_state_pkg::obs_source_s obs = '0;
  decoder_lock_state_pkg::lock_state_s lk = '0;
  int error_cnt = 0;
  int checked = 0;
  reg_host host (.ref_clk_i(ref_clk_i), .rdata_i(rq), .addr_o(ad),
    .wr_o(wr), .rd_o(rd), .wdata_o(wd));
  decoder_lock_state_monitor_regs #(.TONE_ERRORS(2)) DUT (.ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i), .reg_addr_i(ad), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_wdata_i(wd), .reg_rdata_o(rq), .symbol_rate_readback_i(lf[15:0]),
    .observation_select_i(sel), .carrier_sync_i_sample_i(ci),
    .carrier_sync_q_sample_i(cq), .sample_valid_i(sv), .obs_source_i(obs),
    .lock_state_i(lk), .decoder_events_i(ev), .viterbi_error_pulse_i(vp),
    .viterbi_corrected_count_i(lf[23:0]),
    .manual_output_clock_mode_i(1'b0), .rate_clock_i(lf[4]),
    .transport_input_clock_i(1'b0), .irq_n_o(irq_n), .status_o(st),
    .transport_output_clock_o(oc), .test_clock_out_en_o(so[4]),
    .descrambler_off_o(so[3]), .reed_solomon_off_o(so[2]),
    .viterbi_bypass_o(so[1]), .custom_sync_byte_en_o(so[0]),
    .sync_loss_threshold_o(thr), .viterbi_corrected_count_o(vco));
  // Free-running 25 MHz clock
  initial begin
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : step
  // Expected observation word; reserved codes read zero
  function automatic logic [15:0] obs_word(input logic [3:0] c);
    case (c)
      4'h0: return {ci, cq};
      4'h1: return {obs.input_offset_i, obs.input_offset_q};
      4'h3: return obs.rate_search_locked ?
        obs.locked_rate_readout : 16'h0000;
      4'h5: return {obs.dec_ratio_index, 13'h0000};
      4'h6: return {2{obs.freq_lock_detector_value}};
      4'h7: return obs.timing_lock_detector_value;
      4'h8: return obs.phase_lock_detector_value;
      default: return 16'h0000;
    endcase
  endfunction : obs_word
  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    checked++;
    if (g !== x) begin
      error_cnt++;
      $display("ERROR %s exp %h got %h", n, x, g);
    end
  endtask : chk
  task automatic rc(input string n, input logic [7:0] a, input logic [7:0] x);
    host.rd(a, d);
    chk(n, x, d);
  endtask : rc
  task automatic wrap_up;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (8) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    rc("enables", 8'h1F, 8'h00);
    rc("pin_sel", 8'h21, 8'h14);
    rc("setup", 8'h61, 8'h03);
    chk("thr", 8'h05, {5'h00, thr});
    rc("unmapped", 8'h40, 8'h00);
    for (int i = 0; i < 6; i++) begin
      lf = step(lf);
      e = lf[7:0];
      host.go(1'b1, 8'h61, e);
      host.go(1'b1, 8'h06, 8'hFF);
      chk("setup_out", {3'h0, e[6:2]}, {3'h0, so});
      chk("thr", {5'h00, e[1:0]} + 8'h02, {5'h00, thr});
      host.go(1'b1, 8'h1F, e);
      @(posedge ref_clk_i);
      obs <= {lf, step(lf), lf[11:0]};
      lk <= lf[13:8] % 6'h30;
      ci <= lf[23:16];
      cq <= lf[31:24];
      sv <= 1'b1;
      vp <= 1'b1;
      ev <= lf[31:24];
      if (lf[26]) vc = lf[23:0];
      @(posedge ref_clk_i);
      sv <= 1'b0;
      ev <= 8'h00;
      // Two error pulses per round: the tone toggles once each round
      @(posedge ref_clk_i);
      vp <= 1'b0;
      @(posedge ref_clk_i);
      #1 chk("irq_n", {7'h00, ~|(e & lf[31:24])}, {7'h00, irq_n});
      for (int b = 0; b < 3; b++) begin
        chk("vcount", vc[8*b+:8], vco[8*b+:8]);
      end
      rc("flags", 8'h03, lf[31:24]);
      rc("flags_clr", 8'h03, 8'h00);
      rc("lock", 8'h06, {1'b0, lk, 1'b0});
      rc("rate_hi", 8'h74, lf[15:8]);
      rc("rate_lo", 8'h75, lf[7:0]);
      // Each defined code, both bytes read twice to show reads are harmless
      foreach (codes[k]) begin
        @(posedge ref_clk_i);
        c = codes[k];
        sel <= c;
        for (int j = 0; j < 4; j++) begin
          host.rd(8'h7B + j[0], d);
          chk("obs", j[0] ? obs_word(c[3:0]) : (obs_word(c[3:0]) >> 8) &
            (c == 5 ? 8'hE0 : 8'hFF), c == 5 && !j[0] ? d & 8'hE0 : d);
        end
      end
      host.go(1'b1, 8'h21, {4'h1, lf[3:0]});
      repeat (2) @(posedge ref_clk_i);
      #1 chk("status", {7'h00, |(lf[3:1] & {lk.descrambler_locked,
        lk.byte_align_locked, lk.viterbi_locked}) | (lf[0] & !i[0])},
        {7'h00, st});
      chk("oclk", {7'h00, !e[7] && lf[4]}, {7'h00, oc});
      $display("round %0d done", i);
    end
    wrap_up();
  end
endmodule : decoder_lock_state_monitor_regs_tb
`default_nettype wire

// file: testbench/reg_host.sv
/* Host model that drives the register strobe port of the bank.
   Assumes the bank takes strobes on the rising edge of ref_clk_i. */
`default_nettype none
module reg_host (
  // Clock and read answer
  input wire logic ref_clk_i,
  input wire logic [7:0] rdata_i,
  // Strobe port
  output logic [7:0] addr_o = 8'h00,
  output logic wr_o = 1'b0,
  output logic rd_o = 1'b0,
  output logic [7:0] wdata_o = 8'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  // One-cycle strobe; never read and write together
  task automatic go(input logic w, input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk_i);
    addr_o <= a;
    wdata_o <= v;
    wr_o <= w;
    rd_o <= !w;
    @(posedge ref_clk_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
  endtask : go
  // Answer is registered, so look just after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    go(1'b0, a, 8'h00);
    #1 v = rdata_i;
  endtask : rd
endmodule : reg_host
`default_nettype wire
